// ==== include/sbsf_pkg.sv ====
`default_nettype none
package sbsf_pkg;

  // ==========================================================================
  // Bus geometry
  localparam int unsigned SBSF_ADDR_W = 12;
  localparam int unsigned SBSF_DATA_W = 32;
  localparam int unsigned SBSF_SEL_W  = 4;
  localparam int unsigned SBSF_REG_W  = 8;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] SBSF_STATUS_OFS = 12'hb08;
  localparam logic [11:0] SBSF_MASK_OFS   = 12'hb0c;

  // ==========================================================================
  // Status field positions
  localparam int unsigned SBSF_TX_FULL_BIT  = 7;
  localparam int unsigned SBSF_TX_EMPTY_BIT = 6;
  localparam int unsigned SBSF_TX_SLIP_BIT  = 5;
  localparam int unsigned SBSF_LOOP_BIT     = 4;
  localparam int unsigned SBSF_MFLOCK_BIT   = 3;
  localparam int unsigned SBSF_RX_FULL_BIT  = 2;
  localparam int unsigned SBSF_RX_EMPTY_BIT = 1;
  localparam int unsigned SBSF_RX_SLIP_BIT  = 0;

  // Directions index the per-buffer event arrays.
  localparam int unsigned SBSF_DIR_RX = 0;
  localparam int unsigned SBSF_DIR_TX = 1;
  localparam int unsigned SBSF_NDIR   = 2;

  // ==========================================================================
  // Reset values and masks
  localparam logic [7:0]  SBSF_STATUS_RST = 8'he7 & 8'h00;
  localparam logic [7:0]  SBSF_MASK_RST   = 8'h00;
  localparam logic [7:0]  SBSF_EVENT_BITS = 8'he7;
  localparam logic [31:0] SBSF_DATA_ZERO  = 32'h0000_0000;
  localparam logic [23:0] SBSF_PAD_ZERO   = 24'h00_0000;

  // Number of synchroniser stages a lock level passes before the agreement register.
  localparam int unsigned SBSF_SYNC_STAGES = 3;

endpackage : sbsf_pkg
`default_nettype wire

// ==== hw/sbsf_level_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsf_level_sync #(
  parameter int unsigned WIDTH = 2
) (
  // Clock and reset
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  // Levels from the framer
  input  wire logic [WIDTH-1:0] level_in,
  output var  logic [WIDTH-1:0] level_out
);
  import sbsf_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stage2_q;
  logic [WIDTH-1:0] stage3_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] agree;

  // ==========================================================================
  // Checks
  if (WIDTH < 1) begin : g_bad_width
    $error("sbsf_level_sync needs at least one level");
  end

  // A change counts only once the second and third stage agree, which
  // filters a single late-settling sample at the cost of one cycle.
  assign agree = ~(stage2_q ^ stage3_q);

  // The first stage feeds only the second stage.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta_q   <= '0;
      stage2_q <= '0;
      stage3_q <= '0;
      level_q  <= '0;
    end else begin
      meta_q   <= level_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
      level_q  <= (agree & stage3_q) | (~agree & level_q);
    end
  end

  assign level_out = level_q;

endmodule : sbsf_level_sync
`default_nettype wire

// ==== hw/sbsf_status_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsf_status_regs #(
  parameter int unsigned ADDR_W = sbsf_pkg::SBSF_ADDR_W
) (
  // Clock and reset
  input  wire logic                         ref_clk_in,
  input  wire logic                         rst_in,
  // Wishbone classic slave
  input  wire logic                         wb_cyc_in,
  input  wire logic                         wb_stb_in,
  input  wire logic                         wb_we_in,
  input  wire logic [ADDR_W-1:0]            wb_adr_in,
  input  wire logic [sbsf_pkg::SBSF_SEL_W-1:0]  wb_sel_in,
  input  wire logic [sbsf_pkg::SBSF_DATA_W-1:0] wb_dat_in,
  output var  logic [sbsf_pkg::SBSF_DATA_W-1:0] wb_dat_out,
  output var  logic                         wb_ack_out,
  // Transmit slip buffer accesses, same clock
  input  wire logic                         tx_buf_write_in,
  input  wire logic                         tx_buf_full_in,
  input  wire logic                         tx_buf_read_in,
  input  wire logic                         tx_buf_empty_in,
  // Receive slip buffer accesses, same clock
  input  wire logic                         rx_buf_write_in,
  input  wire logic                         rx_buf_full_in,
  input  wire logic                         rx_buf_read_in,
  input  wire logic                         rx_buf_empty_in,
  // Framer lock levels, asynchronous
  input  wire logic                         loop_carrier_frame_sync_in,
  input  wire logic                         multiframe_lock_in,
  // Frame slip commands to the buffer datapath
  output var  logic                         tx_frame_discard_out,
  output var  logic                         tx_frame_repeat_out,
  output var  logic                         rx_frame_discard_out,
  output var  logic                         rx_frame_repeat_out,
  // Interrupt
  output var  logic                         irq_out
);
  import sbsf_pkg::*;

  // ==========================================================================
  // Status register layout
  // Bit 7 records a transmit write into a full store: a dropped frame.
  // Bit 6 records a transmit read from an empty store: a repeated frame.
  // Bit 5 records a transmit slip of either kind.
  // Bit 4 shows live whether loop carrier framing is in sync.
  // Bit 3 shows live whether the receive framer holds multiframe lock.
  // Bit 2 records a receive write into a full store: a dropped frame.
  // Bit 1 records a receive read from an empty store: a repeated frame.
  // Bit 0 records a receive slip of either kind.
  // Recorded bits clear on a read of the register or where ones are
  // written to them; the mask register shares the layout.
  // A slip bit alone cannot say which kind of slip it was, so software
  // looks at the full and empty bits beside it.

  // ==========================================================================
  // Checks
  // The decoder compares offset bits 11 to 2, so narrower buses fail.
  if (ADDR_W < SBSF_ADDR_W) begin : g_bad_addr
    $error("sbsf_status_regs needs at least 12 address bits");
  end

  // The read word is the status byte padded with zeros; a package edit
  // that breaks the sum would move the flags out of lane 0.
  if (SBSF_REG_W + $bits(SBSF_PAD_ZERO) != SBSF_DATA_W) begin : g_bad_pad
    $error("sbsf_status_regs status byte and padding must fill the word");
  end

  // The top field must sit inside the status byte; the others lie below.
  if (SBSF_TX_FULL_BIT >= SBSF_REG_W) begin : g_bad_field
    $error("sbsf_status_regs field position beyond the status byte");
  end

  // Lock bits are live levels; were they among the recorded bits, a read
  // would clear a level that the framer still drives.
  localparam logic LOCK_IN_EVENTS = SBSF_EVENT_BITS[SBSF_LOOP_BIT]
                                  | SBSF_EVENT_BITS[SBSF_MFLOCK_BIT];
  if (LOCK_IN_EVENTS) begin : g_bad_lock_bits
    $error("sbsf_status_regs lock bits must not be recorded bits");
  end

  // Status and mask need words of their own, or a mask write would also
  // clear status and a read could not tell the two apart.
  if ((SBSF_STATUS_OFS >> 2) == (SBSF_MASK_OFS >> 2)) begin : g_same_word
    $error("sbsf_status_regs status and mask share one word");
  end

  // ==========================================================================
  // Address decode
  // Registers are aligned words; the two low address bits are ignored.
  // Comparing whole words keeps a byte access to a neighbouring register
  // from reaching this one.
  function automatic logic f_hit(input logic [ADDR_W-1:0] adr,
                                 input logic [11:0]       ofs);
    logic [ADDR_W-1:0] wide;
    wide = ADDR_W'(ofs);
    return adr[ADDR_W-1:2] == wide[ADDR_W-1:2];
  endfunction : f_hit

  // ==========================================================================
  // Declarations
  // Stored state and its next values.
  logic                     ack_q;
  logic                     ack_d;
  logic [SBSF_DATA_W-1:0]   dat_q;
  logic [SBSF_DATA_W-1:0]   dat_d;
  logic [SBSF_REG_W-1:0]    status_q;
  logic [SBSF_REG_W-1:0]    status_d;
  logic [SBSF_REG_W-1:0]    mask_q;
  logic [SBSF_REG_W-1:0]    mask_d;
  logic                     irq_q;
  logic                     irq_d;
  logic [SBSF_NDIR-1:0]     discard_q;
  logic [SBSF_NDIR-1:0]     repeat_q;

  // Bus request decode.
  wire logic                req;
  wire logic                rd;
  wire logic                wr;
  wire logic                hit_status;
  wire logic                hit_mask;
  wire logic                lane0;
  wire logic                rd_status;
  wire logic                wr_status;
  wire logic                wr_mask;

  // Per-direction views of the buffer strobes and their events.
  wire logic [SBSF_NDIR-1:0] buf_write;
  wire logic [SBSF_NDIR-1:0] buf_full;
  wire logic [SBSF_NDIR-1:0] buf_read;
  wire logic [SBSF_NDIR-1:0] buf_empty;
  logic [SBSF_NDIR-1:0]      ev_full;
  logic [SBSF_NDIR-1:0]      ev_empty;
  logic [SBSF_NDIR-1:0]      ev_slip;

  // Lock levels and the status byte as assembled for a read.
  logic [1:0]               lock_sync;
  wire logic [SBSF_REG_W-1:0] ev_set;
  wire logic [SBSF_REG_W-1:0] rd_clear;
  wire logic [SBSF_REG_W-1:0] wr_clear;
  wire logic [SBSF_REG_W-1:0] lock_bits;
  wire logic [SBSF_REG_W-1:0] status_view;

  // ==========================================================================
  // Lock synchroniser
  // Both lock levels come from the receive framer, outside this clock.
  // Each level passes three stages and an agreement register, so a status
  // read sees a change three to four cycles late, far inside one frame.
  sbsf_level_sync #(
    .WIDTH (2)
  ) u_lock_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .level_in   ({loop_carrier_frame_sync_in, multiframe_lock_in}),
    .level_out  (lock_sync)
  );

  // ==========================================================================
  // Slip event detection
  // The stores raise full and empty themselves; this block only watches
  // the strobes and never stalls them, so a slip is recorded in the same
  // cycle in which the datapath is told to move a frame.
  // Pack both buffers so one loop serves receive and transmit alike.
  assign buf_write[SBSF_DIR_TX] = tx_buf_write_in;
  assign buf_full[SBSF_DIR_TX]  = tx_buf_full_in;
  assign buf_read[SBSF_DIR_TX]  = tx_buf_read_in;
  assign buf_empty[SBSF_DIR_TX] = tx_buf_empty_in;
  assign buf_write[SBSF_DIR_RX] = rx_buf_write_in;
  assign buf_full[SBSF_DIR_RX]  = rx_buf_full_in;
  assign buf_read[SBSF_DIR_RX]  = rx_buf_read_in;
  assign buf_empty[SBSF_DIR_RX] = rx_buf_empty_in;

  for (genvar d = 0; d < SBSF_NDIR; d++) begin : g_dir
    // A write into a full store drops a frame; a read from an empty
    // store repeats one. Either is a slip.
    assign ev_full[d]  = buf_write[d] & buf_full[d];
    assign ev_empty[d] = buf_read[d] & buf_empty[d];
    assign ev_slip[d]  = ev_full[d] | ev_empty[d];

    // The datapath acts on these one-cycle commands to move its
    // pointers by a whole frame.
    always_ff @(posedge ref_clk_in) begin
      if (rst_in) begin
        discard_q[d] <= 1'b0;
        repeat_q[d]  <= 1'b0;
      end else begin
        discard_q[d] <= ev_full[d];
        repeat_q[d]  <= ev_empty[d];
      end
    end
  end

  // Event bits laid out in register order; lock bits stay zero here.
  assign ev_set[SBSF_TX_FULL_BIT]  = ev_full[SBSF_DIR_TX];
  assign ev_set[SBSF_TX_EMPTY_BIT] = ev_empty[SBSF_DIR_TX];
  assign ev_set[SBSF_TX_SLIP_BIT]  = ev_slip[SBSF_DIR_TX];
  assign ev_set[SBSF_LOOP_BIT]     = 1'b0;
  assign ev_set[SBSF_MFLOCK_BIT]   = 1'b0;
  assign ev_set[SBSF_RX_FULL_BIT]  = ev_full[SBSF_DIR_RX];
  assign ev_set[SBSF_RX_EMPTY_BIT] = ev_empty[SBSF_DIR_RX];
  assign ev_set[SBSF_RX_SLIP_BIT]  = ev_slip[SBSF_DIR_RX];

  // ==========================================================================
  // Lock view
  // Lock bits are live levels, never stored, so writes cannot touch them.
  // Only the two lock positions carry a level; the recorded bits come
  // from the stored flags and are tied low in this view.
  assign lock_bits[SBSF_TX_FULL_BIT]  = 1'b0;
  assign lock_bits[SBSF_TX_EMPTY_BIT] = 1'b0;
  assign lock_bits[SBSF_TX_SLIP_BIT]  = 1'b0;
  assign lock_bits[SBSF_LOOP_BIT]     = lock_sync[1];
  assign lock_bits[SBSF_MFLOCK_BIT]   = lock_sync[0];
  assign lock_bits[SBSF_RX_FULL_BIT]  = 1'b0;
  assign lock_bits[SBSF_RX_EMPTY_BIT] = 1'b0;
  assign lock_bits[SBSF_RX_SLIP_BIT]  = 1'b0;

  assign status_view = (status_q & SBSF_EVENT_BITS) | lock_bits;

  // ==========================================================================
  // Bus request decode
  // A request is taken on the first edge that sees cyc and stb high with
  // ack low. A write or a clearing read acts on that edge, and ack and the
  // read word stand for exactly the next cycle. The read word is the view
  // from before the clear, so an event in the taking cycle is not lost but
  // shows up on the following read.
  // Only lane 0 carries the byte; a request with that lane off is answered
  // but neither writes nor clears.
  // A request is taken once; the registered ack blocks a second take.
  assign req        = wb_cyc_in & wb_stb_in & ~ack_q;
  assign rd         = req & ~wb_we_in;
  assign wr         = req & wb_we_in;
  assign hit_status = f_hit(wb_adr_in, SBSF_STATUS_OFS);
  assign hit_mask   = f_hit(wb_adr_in, SBSF_MASK_OFS);
  assign lane0      = wb_sel_in[0];
  assign rd_status  = rd & hit_status & lane0;
  assign wr_status  = wr & hit_status & lane0;
  assign wr_mask    = wr & hit_mask & lane0;

  // ==========================================================================
  // Flag clearing
  // Write-one-to-clear lets software that polls the interrupt line retire
  // the bits it has handled without disturbing the others.
  // A read clears every event flag; a written one clears that flag alone.
  assign rd_clear = rd_status ? SBSF_EVENT_BITS : '0;
  assign wr_clear = wr_status ? (wb_dat_in[SBSF_REG_W-1:0]
                                 & SBSF_EVENT_BITS) : '0;

  // Set is applied after clear, so a same-cycle event survives the read.
  always_comb begin
    status_d = ((status_q & ~rd_clear & ~wr_clear) | ev_set)
               & SBSF_EVENT_BITS;
    mask_d   = wr_mask ? (wb_dat_in[SBSF_REG_W-1:0] & SBSF_EVENT_BITS)
                       : mask_q;
    irq_d    = |(status_d & mask_d);
  end

  // ==========================================================================
  // Read data and acknowledge
  // Unmapped addresses still ack with zero data so a master never hangs.
  // The word is registered with ack and is zero in every other cycle, so a
  // master that samples late sees zero rather than stale flags.
  always_comb begin
    ack_d = req;
    dat_d = SBSF_DATA_ZERO;
    if (rd && hit_status) begin
      dat_d = {SBSF_PAD_ZERO, status_view};
    end else if (rd && hit_mask) begin
      dat_d = {SBSF_PAD_ZERO, mask_q};
    end
  end

  // ==========================================================================
  // Register state
  // Lock bits are not stored, so after a reset they read zero until the
  // synchroniser has settled on the framer's levels again.
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ack_q    <= 1'b0;
      dat_q    <= SBSF_DATA_ZERO;
      status_q <= SBSF_STATUS_RST;
      mask_q   <= SBSF_MASK_RST;
      irq_q    <= 1'b0;
    end else begin
      ack_q    <= ack_d;
      dat_q    <= dat_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      irq_q    <= irq_d;
    end
  end

  // ==========================================================================
  // Outputs
  // Every output is a flip-flop, so the datapath sees clean pulses.
  // The frame commands lag the strobes by one cycle; the datapath must not
  // assume that a strobe in that next cycle already sees the move.
  assign wb_ack_out           = ack_q;
  assign wb_dat_out           = dat_q;
  assign irq_out              = irq_q;
  assign tx_frame_discard_out = discard_q[SBSF_DIR_TX];
  assign tx_frame_repeat_out  = repeat_q[SBSF_DIR_TX];
  assign rx_frame_discard_out = discard_q[SBSF_DIR_RX];
  assign rx_frame_repeat_out  = repeat_q[SBSF_DIR_RX];

endmodule : sbsf_status_regs
`default_nettype wire

// ==== testbench/sbsf_status_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsf_status_regs_asserts (
  // Clock and reset
  input wire logic                              ref_clk_in,
  input wire logic                              rst_in,
  // Register bus
  input wire logic                              wb_cyc_in,
  input wire logic                              wb_stb_in,
  input wire logic [sbsf_pkg::SBSF_DATA_W-1:0]  wb_dat_out,
  input wire logic                              wb_ack_out,
  // Buffer accesses
  input wire logic                              tx_buf_write_in,
  input wire logic                              tx_buf_full_in,
  input wire logic                              tx_buf_read_in,
  input wire logic                              tx_buf_empty_in,
  input wire logic                              rx_buf_write_in,
  input wire logic                              rx_buf_full_in,
  input wire logic                              rx_buf_read_in,
  input wire logic                              rx_buf_empty_in,
  // Frame slip commands
  input wire logic                              tx_frame_discard_out,
  input wire logic                              tx_frame_repeat_out,
  input wire logic                              rx_frame_discard_out,
  input wire logic                              rx_frame_repeat_out
);
  import sbsf_pkg::*;
  // ==========================================================================
  // Properties, all in the one clock domain.
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_tx_del;
    tx_buf_write_in && tx_buf_full_in |=> tx_frame_discard_out;
  endproperty
  a_tx_del: assert property (p_tx_del) else $error("tx discard missing");
  property p_tx_rep;
    tx_buf_read_in && tx_buf_empty_in |=> tx_frame_repeat_out;
  endproperty
  a_tx_rep: assert property (p_tx_rep) else $error("tx repeat missing");
  property p_rx_del;
    rx_buf_write_in && rx_buf_full_in |=> rx_frame_discard_out;
  endproperty
  a_rx_del: assert property (p_rx_del) else $error("rx discard missing");
  property p_rx_rep;
    rx_buf_read_in && rx_buf_empty_in |=> rx_frame_repeat_out;
  endproperty
  a_rx_rep: assert property (p_rx_rep) else $error("rx repeat missing");
  // A discard without its cause would throw away good frames.
  property p_del_cause;
    tx_frame_discard_out |-> $past(tx_buf_write_in && tx_buf_full_in);
  endproperty
  a_del_cause: assert property (p_del_cause) else $error("stray discard");
  property p_rep_cause;
    rx_frame_repeat_out |-> $past(rx_buf_read_in && rx_buf_empty_in);
  endproperty
  a_rep_cause: assert property (p_rep_cause) else $error("stray repeat");
  property p_tx_rep_cause;
    tx_frame_repeat_out |-> $past(tx_buf_read_in && tx_buf_empty_in);
  endproperty
  a_tx_rep_cause: assert property (p_tx_rep_cause)
    else $error("stray tx repeat");
  property p_rx_del_cause;
    rx_frame_discard_out |-> $past(rx_buf_write_in && rx_buf_full_in);
  endproperty
  a_rx_del_cause: assert property (p_rx_del_cause)
    else $error("stray rx discard");
  property p_ack;
    wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not a single pulse");
  property p_dat_idle;
    !wb_ack_out |-> wb_dat_out == SBSF_DATA_ZERO;
  endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
endmodule : sbsf_status_regs_asserts
bind sbsf_status_regs sbsf_status_regs_asserts i_chk (.*);
`default_nettype wire

// ==== testbench/sbsf_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module sbsf_host_model (
  // Clock
  input  wire logic                              ref_clk_in,
  // Wishbone classic master
  output var  logic                              wb_cyc_out,
  output var  logic                              wb_stb_out,
  output var  logic                              wb_we_out,
  output var  logic [sbsf_pkg::SBSF_ADDR_W-1:0]  wb_adr_out,
  output var  logic [sbsf_pkg::SBSF_SEL_W-1:0]   wb_sel_out,
  output var  logic [sbsf_pkg::SBSF_DATA_W-1:0]  wb_dat_out,
  input  wire logic [sbsf_pkg::SBSF_DATA_W-1:0]  wb_dat_in,
  input  wire logic                              wb_ack_in
);
  import sbsf_pkg::*;
  // ==========================================================================
  // Idle bus at time zero.
  initial begin
    wb_cyc_out = 1'b0;
    wb_stb_out = 1'b0;
    wb_we_out  = 1'b0;
    wb_adr_out = 12'h000;
    wb_sel_out = 4'h0;
    wb_dat_out = SBSF_DATA_ZERO;
  end
  // One classic cycle; no latency is assumed, the bench watchdog cuts hangs.
  task automatic xfer(input logic we, input logic [11:0] adr,
                      input logic [3:0] sel, input logic [31:0] wdat,
                      output logic [31:0] rdat);
    @(posedge ref_clk_in);
    wb_cyc_out <= 1'b1;
    wb_stb_out <= 1'b1;
    wb_we_out  <= we;
    wb_adr_out <= adr;
    wb_sel_out <= sel;
    wb_dat_out <= wdat;
    @(posedge ref_clk_in);
    while (wb_ack_in !== 1'b1) @(posedge ref_clk_in);
    // The caller tells deletion from repetition by full and empty bits.
    rdat = wb_dat_in;
    wb_cyc_out <= 1'b0;
    wb_stb_out <= 1'b0;
    wb_we_out  <= 1'b0;
    // Released lines carry junk so a stale value cannot pass for a live one.
    wb_adr_out <= ~adr;
    wb_dat_out <= ~wdat;
  endtask : xfer
endmodule : sbsf_host_model
`default_nettype wire

// ==== testbench/tb_slip_buffer_status_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
  fail_count++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
  end end
module tb_slip_buffer_status_flags;
  import sbsf_pkg::*;
  // ==========================================================================
  // Stimulus and wiring.
  localparam logic [7:0] EV_TAB [4] = '{8'hc0, 8'h30, 8'h0c, 8'h03};
  localparam logic [7:0] ST_TAB [4] = '{8'ha0, 8'h60, 8'h05, 8'h03};
  logic        ref_clk_in;
  logic        rst_in;
  logic [7:0]  buf_drv;
  logic        loop_in;
  logic        mfl_in;
  logic        cyc, stb, we, ack, irq;
  logic [11:0] adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [31:0] peek;
  int          n_checks;
  int          fail_count;
  // Half period of 2 ns gives 250 MHz.
  initial ref_clk_in = 1'b0;
  always #2 ref_clk_in = ~ref_clk_in;
  sbsf_host_model i_host (.ref_clk_in(ref_clk_in), .wb_cyc_out(cyc),
    .wb_stb_out(stb), .wb_we_out(we), .wb_adr_out(adr), .wb_sel_out(sel),
    .wb_dat_out(wdat), .wb_dat_in(rdat), .wb_ack_in(ack));
  sbsf_status_regs i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
    .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .tx_buf_write_in(buf_drv[7]), .tx_buf_full_in(buf_drv[6]),
    .tx_buf_read_in(buf_drv[5]), .tx_buf_empty_in(buf_drv[4]),
    .rx_buf_write_in(buf_drv[3]), .rx_buf_full_in(buf_drv[2]),
    .rx_buf_read_in(buf_drv[1]), .rx_buf_empty_in(buf_drv[0]),
    .loop_carrier_frame_sync_in(loop_in), .multiframe_lock_in(mfl_in),
    .tx_frame_discard_out(), .tx_frame_repeat_out(),
    .rx_frame_discard_out(), .rx_frame_repeat_out(), .irq_out(irq));
  // The read helper compares the whole word, so upper bits must read zero.
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] d;
    i_host.xfer(1'b0, a, 4'h1, SBSF_DATA_ZERO, d);
    `CHK(d, {SBSF_PAD_ZERO, e})
  endtask : rd
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] d;
    i_host.xfer(1'b1, a, 4'h1, {SBSF_PAD_ZERO, v}, d);
  endtask : wr
  // One cycle of buffer activity, then quiet.
  task automatic pulse(input logic [7:0] v);
    @(posedge ref_clk_in);
    buf_drv <= v;
    @(posedge ref_clk_in);
    buf_drv <= 8'h00;
  endtask : pulse
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // The tests take well under two hundred cycles; 10 us is ample margin.
  initial begin
    #10000;
    fail_count++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    final_report();
  end
  // Main sequence.
  initial begin
    n_checks = 0;
    fail_count = 0;
    rst_in = 1'b1;
    buf_drv = 8'h00;
    loop_in = 1'b0;
    mfl_in = 1'b0;
    repeat (3) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    rd(SBSF_STATUS_OFS, 8'h00);
    rd(12'hb10, 8'h00);
    wr(SBSF_MASK_OFS, 8'hff);
    rd(SBSF_MASK_OFS, 8'he7);
    $display("test reset_and_map done");
    for (int i = 0; i < 4; i++) begin
      pulse(EV_TAB[i]);
      rd(SBSF_STATUS_OFS, ST_TAB[i]);
      rd(SBSF_STATUS_OFS, 8'h00);
    end
    pulse(8'haa);
    pulse(8'h55);
    rd(SBSF_STATUS_OFS, 8'h00);
    $display("test slip_events done");
    wr(SBSF_MASK_OFS, 8'h20);
    pulse(8'h0c);
    @(posedge ref_clk_in);
    `CHK(irq, 1'b0)
    pulse(8'hc0);
    @(posedge ref_clk_in);
    `CHK(irq, 1'b1)
    wr(SBSF_STATUS_OFS, 8'h20);
    @(posedge ref_clk_in);
    `CHK(irq, 1'b0)
    rd(SBSF_STATUS_OFS, 8'h85);
    $display("test interrupt done");
    loop_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    wr(SBSF_STATUS_OFS, 8'hff);
    rd(SBSF_STATUS_OFS, 8'h10);
    loop_in <= 1'b0;
    mfl_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    rd(SBSF_STATUS_OFS, 8'h08);
    $display("test lock_levels done");
    // A read without lane 0 shows the flags but must leave them set.
    pulse(8'h03);
    i_host.xfer(1'b0, SBSF_STATUS_OFS, 4'h2, SBSF_DATA_ZERO, peek);
    `CHK(peek, {SBSF_PAD_ZERO, 8'h0b})
    rd(SBSF_STATUS_OFS, 8'h0b);
    $display("test lane_gating done");
    fork
      rd(SBSF_STATUS_OFS, 8'h08);
      pulse(8'hc0);
    join
    rd(SBSF_STATUS_OFS, 8'ha8);
    $display("test read_collision done");
    // A reset in mid-run drops the interrupt, the flags and the mask.
    pulse(8'hc0);
    rst_in <= 1'b1;
    repeat (2) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    `CHK(irq, 1'b0)
    rd(SBSF_STATUS_OFS, 8'h00);
    rd(SBSF_MASK_OFS, 8'h00);
    $display("test mid_reset done");
    final_report();
  end
endmodule : tb_slip_buffer_status_flags
`default_nettype wire
